// ===== logic/cmc_ctrl.sv
// comparator control and status logic behind an axi4-lite register slave
// Summary of operation
// RULE1: both comparator levels read at configuration bits 7:6; writes there ignored
// RULE2: reported level is raw comparison xor that comparator's invert bit
// RULE3: invert bits 5 and 4 affect both status bits and pins
// RULE4: routing enabled puts each unsynchronized comparator level on its pin
// RULE5: direction bits still enable the pin drivers while routed
// RULE6: auxiliary bit 1 picks timer gate source
// RULE7: gate select set picks external pin, clear picks comparator two; resets 1
// RULE8: sync bit 0 set latches comparator two on timer clock falling edge
// RULE9: with prescaler in use, latch uses prescaler output instead
// RULE10: latch on falling edge, timer counts rising edge, avoiding race
// RULE11: software should enable sync when comparator two gates the timer
// RULE12: change flags bits 4,3 set while level differs from latched reference
// RULE13: software writes 0 to clear, writing 1 sets a flag
// RULE14: request needs flag enable, peripheral gate bit 6 and global gate
// RULE15: any configuration access reloads reference; persisting mismatch keeps setting
// RULE16: change at read's second phase may miss its flag; here the old reference still sets the flag in the access cycle
// RULE17: reference has 4-bit value bits 3:0 and range bit 5, 1 low
// RULE18: reference bit 7 powers reference; cleared ties output to ground
// RULE19: reference bits 6 and 4 always read zero
// RULE20: comparators and reference run in sleep; mode 111 and bit 7 off
// RULE21: comparator interrupt wakes; global gate set vectors, else continues
// RULE22: waking leaves the three comparator registers unchanged
// RULE23: reset restores registers: mode 000, analog inputs, reference off
// RULE24: mode field decodes combinationally to fixed routing configurations
`timescale 1ns/1ns
module cmc_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // axi4-lite write channels
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog comparator results, 1 when vin+ above vin-
   input wire logic cmp_one_raw,
   input wire logic cmp_two_raw,
   // timer side
   input wire logic timer_clk_src,
   input wire logic timer_prescaled_clk,
   input wire logic timer_prescale_used,
   input wire logic external_gate_pin,
   output logic timer_gate,
   // port pins shared with comparator outputs
   input wire logic port_a_data_bit,
   input wire logic port_c_data_bit,
   output logic cmp_one_out_pin_o,
   output logic cmp_one_out_pin_oe,
   output logic cmp_two_out_pin_o,
   output logic cmp_two_out_pin_oe,
   // analog control
   output logic [2:0] cmp_mode_field,
   output logic cmp_enabled,
   output logic cmp_outputs_routed,
   output logic ref_power_enable,
   output logic ref_range_select,
   output logic [3:0] ref_level_value,
   output logic ref_tied_ground,
   // processor side
   input wire logic sleep_active,
   output logic irq_request,
   output logic wake_request,
   output logic wake_to_vector
);

   logic [7:0] gic_reg;
   logic [7:0] pir_reg;
   logic [5:0] cfg_reg;
   logic [1:0] aux_reg;
   logic [5:0] tra_reg;
   logic [5:0] trc_reg;
   logic [7:0] pie_reg;
   logic [7:0] vrc_reg;
   logic [1:0] ref_lvl_reg;
   logic [1:0] mism;
   logic lvl_one;
   logic lvl_two;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [11:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic do_write;
   logic rd_take;
   logic wr_mapped;
   logic rd_mapped;
   logic [7:0] rd_val;
   logic cfg_access;
   logic tsrc;
   logic tsrc_prev_reg;
   logic tsrc_fall;
   logic two_latched_reg;
   logic flag_pend;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // true when a byte address names the given register index
   function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
      hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx) && (addr[1:0] == 2'h0);
   endfunction : hit

   function automatic logic mapped(input logic [11:0] addr);
      mapped = hit(addr, cmc_pkg::IDX_GIC) || hit(addr, cmc_pkg::IDX_PIR) ||
               hit(addr, cmc_pkg::IDX_CFG) || hit(addr, cmc_pkg::IDX_AUX) ||
               hit(addr, cmc_pkg::IDX_TRA) || hit(addr, cmc_pkg::IDX_TRC) ||
               hit(addr, cmc_pkg::IDX_PIE) || hit(addr, cmc_pkg::IDX_VRC);
   endfunction : mapped

   // reported levels: raw result xor invert bit
   assign lvl_one = cmp_one_raw ^ cfg_reg[cmc_pkg::CFG_INV_ONE]; // RULE2 RULE3
   assign lvl_two = cmp_two_raw ^ cfg_reg[cmc_pkg::CFG_INV_TWO]; // RULE2 RULE3

   // write channel: address and data may arrive in either order
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_mapped = mapped(aw_addr_reg);
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
      end else if (s_axi_awvalid && !aw_hold_reg) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_hold_reg) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_hold_reg <= 1'b0;
      end
   end

   // response: unmapped addresses answer slverr and change nothing
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= cmc_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // register write strobes; only byte lane 0 carries data
   logic we_gic, we_pir, we_cfg, we_aux, we_tra, we_trc, we_pie, we_vrc;
   assign we_gic = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_GIC);
   assign we_pir = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_PIR);
   assign we_cfg = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_CFG);
   assign we_aux = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_AUX);
   assign we_tra = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_TRA);
   assign we_trc = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_TRC);
   assign we_pie = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_PIE);
   assign we_vrc = do_write && w_lane_reg && hit(aw_addr_reg, cmc_pkg::IDX_VRC);

   // plain control registers; sleep has no path into them, so wake keeps them
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         gic_reg <= cmc_pkg::GIC_RST; // RULE23
         cfg_reg <= cmc_pkg::CFG_RST; // RULE23
         aux_reg <= cmc_pkg::AUX_RST; // RULE7 RULE23
         vrc_reg <= cmc_pkg::VRC_RST; // RULE23
         tra_reg <= cmc_pkg::DIR_RST;
         trc_reg <= cmc_pkg::DIR_RST;
         pie_reg <= cmc_pkg::PIE_RST;
      end else begin
         if (we_gic) gic_reg <= w_data_reg;
         if (we_cfg) cfg_reg <= w_data_reg[5:0]; // RULE1 RULE22
         if (we_aux) aux_reg <= w_data_reg[1:0]; // RULE22
         if (we_vrc) vrc_reg <= w_data_reg & cmc_pkg::VRC_WMASK; // RULE19 RULE22
         if (we_tra) tra_reg <= w_data_reg[5:0];
         if (we_trc) trc_reg <= w_data_reg[5:0];
         if (we_pie) pie_reg <= w_data_reg;
      end
   end

   // read mux; status bits come live from the comparators
   always_comb begin
      rd_val = 8'h00;
      if (hit(s_axi_araddr, cmc_pkg::IDX_GIC)) rd_val = gic_reg;
      if (hit(s_axi_araddr, cmc_pkg::IDX_PIR)) rd_val = pir_reg;
      if (hit(s_axi_araddr, cmc_pkg::IDX_CFG)) rd_val = {lvl_two, lvl_one, cfg_reg}; // RULE1
      if (hit(s_axi_araddr, cmc_pkg::IDX_AUX)) rd_val = {6'h00, aux_reg};
      if (hit(s_axi_araddr, cmc_pkg::IDX_TRA)) rd_val = {2'h0, tra_reg};
      if (hit(s_axi_araddr, cmc_pkg::IDX_TRC)) rd_val = {2'h0, trc_reg};
      if (hit(s_axi_araddr, cmc_pkg::IDX_PIE)) rd_val = pie_reg;
      if (hit(s_axi_araddr, cmc_pkg::IDX_VRC)) rd_val = vrc_reg; // RULE19
   end

   // read channel: one outstanding read, data one cycle after address
   assign s_axi_arready = !rvalid_reg;
   assign rd_take = s_axi_arvalid && !rvalid_reg;
   assign rd_mapped = mapped(s_axi_araddr);
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= cmc_pkg::RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_val};
         rresp_reg <= rd_mapped ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // any read or write of the configuration register reloads the reference
   assign cfg_access = (rd_take && hit(s_axi_araddr, cmc_pkg::IDX_CFG)) ||
                       (do_write && hit(aw_addr_reg, cmc_pkg::IDX_CFG));
   assign mism = {lvl_two, lvl_one} ^ ref_lvl_reg; // RULE12

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ref_lvl_reg <= 2'h0;
      end else if (cfg_access) begin
         ref_lvl_reg <= {lvl_two, lvl_one}; // RULE15
      end
   end

   // change flags: mismatch sets, set wins over a software clear in the same cycle;
   // a change landing on the access cycle is caught by the old reference, never lost
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pir_reg <= cmc_pkg::PIR_RST;
      end else if (we_pir) begin
         pir_reg <= w_data_reg | {3'h0, mism, 3'h0}; // RULE13 RULE16
      end else begin
         pir_reg <= pir_reg | {3'h0, mism, 3'h0}; // RULE12 RULE15
      end
   end

   // interrupt gating; flags set whatever the enables
   assign flag_pend = |(pir_reg[cmc_pkg::FLG_TWO:cmc_pkg::FLG_ONE] &
                        pie_reg[cmc_pkg::FLG_TWO:cmc_pkg::FLG_ONE]);
   assign irq_request = flag_pend && gic_reg[cmc_pkg::GIC_PERIPH] &&
                        gic_reg[cmc_pkg::GIC_GLOBAL]; // RULE14
   // wake needs no global gate; the gate only decides whether to vector
   assign wake_request = sleep_active && flag_pend && gic_reg[cmc_pkg::GIC_PERIPH]; // RULE21
   assign wake_to_vector = wake_request && gic_reg[cmc_pkg::GIC_GLOBAL]; // RULE21

   // comparator two sync latch, clocked by the timer source's falling edge;
   // the timer counts on the rising edge, so gate and count never race
   assign tsrc = timer_prescale_used ? timer_prescaled_clk : timer_clk_src; // RULE9
   assign tsrc_fall = tsrc_prev_reg && !tsrc; // RULE10

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tsrc_prev_reg <= 1'b0;
      end else begin
         tsrc_prev_reg <= tsrc;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         two_latched_reg <= 1'b0;
      end else if (aux_reg[cmc_pkg::AUX_SYNC] && tsrc_fall) begin
         two_latched_reg <= lvl_two; // RULE8
      end
   end

   // gate source; without sync the gate may change mid-count (software's choice)
   assign timer_gate = aux_reg[cmc_pkg::AUX_GSS] ? external_gate_pin : // RULE6 RULE7
                       (aux_reg[cmc_pkg::AUX_SYNC] ? two_latched_reg : lvl_two); // RULE8 RULE11

   // mode decode; modes keep running in sleep since nothing here looks at it
   assign cmp_mode_field = cfg_reg[2:0];
   assign cmp_enabled = (cfg_reg[2:0] != cmc_pkg::MODE_RESET) &&
                        (cfg_reg[2:0] != cmc_pkg::MODE_OFF); // RULE20 RULE23 RULE24
   assign cmp_outputs_routed = (cfg_reg[2:0] == cmc_pkg::MODE_ROUTE_A) ||
                               (cfg_reg[2:0] == cmc_pkg::MODE_ROUTE_B); // RULE24

   // pins carry the unsynchronized levels when routed; direction bit still gates driver
   assign cmp_one_out_pin_o = cmp_outputs_routed ? lvl_one : port_a_data_bit; // RULE4
   assign cmp_two_out_pin_o = cmp_outputs_routed ? lvl_two : port_c_data_bit; // RULE4
   assign cmp_one_out_pin_oe = tra_reg[cmc_pkg::PIN_A_BIT]; // RULE5
   assign cmp_two_out_pin_oe = trc_reg[cmc_pkg::PIN_C_BIT]; // RULE5

   // reference ladder control
   assign ref_power_enable = vrc_reg[cmc_pkg::VRC_EN]; // RULE18 RULE20
   assign ref_tied_ground = !vrc_reg[cmc_pkg::VRC_EN]; // RULE18
   assign ref_range_select = vrc_reg[cmc_pkg::VRC_RANGE]; // RULE17
   assign ref_level_value = vrc_reg[3:0]; // RULE17

   // checks
   a_status_read: assert property ( // RULE1
      rd_take && hit(s_axi_araddr, cmc_pkg::IDX_CFG) |=>
      s_axi_rdata[7:6] == $past({lvl_two, lvl_one}))
      else $error("status bits not the live levels");
   a_invert_flip: assert property ( // RULE2
      $changed(cfg_reg[cmc_pkg::CFG_INV_ONE]) && $stable(cmp_one_raw) |-> $changed(lvl_one))
      else $error("invert bit did not flip level");
   a_pin_route: assert property ( // RULE4
      cmp_outputs_routed |-> cmp_two_out_pin_o == (cmp_two_raw ^ cfg_reg[cmc_pkg::CFG_INV_TWO]))
      else $error("routed pin not comparator level");
   a_pin_enable: assert property ( // RULE5
      we_tra |=> cmp_one_out_pin_oe == $past(w_data_reg[cmc_pkg::PIN_A_BIT]))
      else $error("pin enable not from direction bit");
   a_gate_ext: assert property ( // RULE7
      we_aux && w_data_reg[cmc_pkg::AUX_GSS] |=> timer_gate == external_gate_pin)
      else $error("gate not external pin");
   a_sync_latch: assert property ( // RULE8
      aux_reg[cmc_pkg::AUX_SYNC] && tsrc_fall |=> two_latched_reg == $past(lvl_two))
      else $error("sync latch missed falling edge");
   a_sync_hold: assert property ( // RULE10
      !tsrc_fall |=> $stable(two_latched_reg))
      else $error("sync latch moved off falling edge");
   a_flag_set: assert property ( // RULE12
      mism[1] |=> pir_reg[cmc_pkg::FLG_TWO] [*1] ##1 1'b1)
      else $error("mismatch did not set flag");
   a_flag_clear: assert property ( // RULE13
      we_pir && mism == 2'h0 |=> pir_reg == $past(w_data_reg))
      else $error("flag write not taken");
   a_irq_gate: assert property ( // RULE14
      irq_request |-> gic_reg[cmc_pkg::GIC_GLOBAL] && gic_reg[cmc_pkg::GIC_PERIPH] && flag_pend)
      else $error("request without all gates");
   a_ref_reload: assert property ( // RULE15
      cfg_access ##1 (mism == 2'h0) [*2] |-> $stable(pir_reg) || $past(we_pir))
      else $error("flag moved without mismatch");
   a_ref_zero: assert property ( // RULE19
      we_vrc |=> vrc_reg[6] == 1'b0 && vrc_reg[4] == 1'b0)
      else $error("reserved reference bits set");
   a_write_resp: assert property (
      do_write |=> s_axi_bvalid)
      else $error("write not answered");
   c_flag_cycle: cover property (mism != 2'h0 ##1 cfg_access ##[1:20] we_pir);
   c_wake_vector: cover property (wake_to_vector);
   c_sync_gate: cover property (!aux_reg[cmc_pkg::AUX_GSS] && aux_reg[cmc_pkg::AUX_SYNC] && tsrc_fall);
   c_routed_pin: cover property (cmp_outputs_routed && !cmp_one_out_pin_oe);

endmodule : cmc_ctrl

// ===== shared/cmc_pkg.sv
// constants for the comparator control block: register map, fields, resets
package cmc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_GIC = 8'h0b;
   localparam logic [7:0] IDX_PIR = 8'h0c;
   localparam logic [7:0] IDX_CFG = 8'h19;
   localparam logic [7:0] IDX_AUX = 8'h1a;
   localparam logic [7:0] IDX_TRA = 8'h85;
   localparam logic [7:0] IDX_TRC = 8'h87;
   localparam logic [7:0] IDX_PIE = 8'h8c;
   localparam logic [7:0] IDX_VRC = 8'h99;
   localparam int unsigned ADDR_W = 12;
   // reset values
   localparam logic [7:0] GIC_RST = 8'h00;
   localparam logic [7:0] PIR_RST = 8'h00;
   localparam logic [5:0] CFG_RST = 6'h00;
   localparam logic [1:0] AUX_RST = 2'h2;
   localparam logic [5:0] DIR_RST = 6'h3f;
   localparam logic [7:0] PIE_RST = 8'h00;
   localparam logic [7:0] VRC_RST = 8'h00;
   // writable masks
   localparam logic [7:0] VRC_WMASK = 8'haf;
   // field positions
   localparam int unsigned CFG_LVL_TWO = 7;
   localparam int unsigned CFG_LVL_ONE = 6;
   localparam int unsigned CFG_INV_TWO = 5;
   localparam int unsigned CFG_INV_ONE = 4;
   localparam int unsigned AUX_GSS = 1;
   localparam int unsigned AUX_SYNC = 0;
   localparam int unsigned FLG_TWO = 4;
   localparam int unsigned FLG_ONE = 3;
   localparam int unsigned GIC_GLOBAL = 7;
   localparam int unsigned GIC_PERIPH = 6;
   localparam int unsigned VRC_EN = 7;
   localparam int unsigned VRC_RANGE = 5;
   localparam int unsigned PIN_A_BIT = 2;
   localparam int unsigned PIN_C_BIT = 4;
   // mode field values
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] MODE_OFF = 3'h7;
   localparam logic [2:0] MODE_ROUTE_A = 3'h3;
   localparam logic [2:0] MODE_ROUTE_B = 3'h6;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmc_pkg

// ===== verification/cmc_ctrl_bench.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module cmc_ctrl_bench;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] vin_one_plus = 8'h10, vin_two_plus = 8'h10;
   logic cmp_one_raw, cmp_two_raw, timer_clk_src, timer_prescaled_clk, timer_gate;
   logic timer_prescale_used = 1'b0, external_gate_pin = 1'b0, sleep_active = 1'b0;
   logic port_a_data_bit = 1'b0, port_c_data_bit = 1'b1;
   logic cmp_one_out_pin_o, cmp_one_out_pin_oe, cmp_two_out_pin_o, cmp_two_out_pin_oe;
   logic cmp_enabled, cmp_outputs_routed, ref_power_enable, ref_range_select, ref_tied_ground;
   logic irq_request, wake_request, wake_to_vector;
   logic [2:0] cmp_mode_field;
   logic [3:0] ref_level_value;
   int num_errors = 0, checks_done = 0;
   logic [7:0] idx_tab [8] = '{cmc_pkg::IDX_GIC, cmc_pkg::IDX_PIR, cmc_pkg::IDX_CFG, cmc_pkg::IDX_AUX,
      cmc_pkg::IDX_TRA, cmc_pkg::IDX_TRC, cmc_pkg::IDX_PIE, cmc_pkg::IDX_VRC};
   logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h3f, 8'h3f, 8'h00, 8'h00};

   cmc_ctrl uut (.*);
   // minus inputs sit at 8'h20; the bench moves only the plus inputs
   cmc_far_side #(.HALF_PERIOD(4)) far (.sys_clk, .reset, .vin_one_plus, .vin_one_minus(8'h20), .vin_two_plus,
      .vin_two_minus(8'h20), .cmp_one_raw, .cmp_two_raw, .timer_clk_src, .timer_prescaled_clk);

   // 125 MHz clock
   initial forever #4 sys_clk = ~sys_clk;

   task automatic end_of_test;
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction : ba

   // handshakes judged mid-cycle, released after the edge
   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] resp);
      logic aw_hit, w_hit, b_hit;
      b_hit = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_hit) begin
         @(negedge sys_clk);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         b_hit = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge sys_clk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic ar_hit, r_hit;
      r_hit = 1'b0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_hit) begin
         @(negedge sys_clk);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit = (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge sys_clk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      axi_wr(ba(idx), d, rsp);
      `CHK(rsp, cmc_pkg::RESP_OKAY)
      @(negedge sys_clk);
   endtask : wr

   task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
      axi_rd(ba(idx), rd, rsp);
      `CHK(rd, {24'h0, exp})
      `CHK(rsp, cmc_pkg::RESP_OKAY)
   endtask : chk_rd

   task automatic set_raw(input logic one, input logic two);
      @(posedge sys_clk);
      vin_one_plus <= one ? 8'h30 : 8'h10;
      vin_two_plus <= two ? 8'h30 : 8'h10;
      @(negedge sys_clk);
   endtask : set_raw

   // flip comparator two just after a timer clock rise, watch the gate
   task automatic gate_step(input logic sync, input logic pre);
      logic nv;
      nv = ~cmp_two_raw;
      do @(negedge sys_clk); while ((pre ? timer_prescaled_clk : timer_clk_src) !== 1'b0);
      do @(negedge sys_clk); while ((pre ? timer_prescaled_clk : timer_clk_src) !== 1'b1);
      set_raw(cmp_one_raw, nv);
      @(negedge sys_clk);
      `CHK(timer_gate, sync ? ~nv : nv)
      repeat (4) @(negedge sys_clk);
      `CHK(timer_gate, (sync && pre) ? ~nv : nv)
      repeat (4) @(negedge sys_clk);
      `CHK(timer_gate, nv)
   endtask : gate_step

   // far beyond the test length; reaching it means a hang
   initial begin
      #200000;
      num_errors++;
      end_of_test;
   end

   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (int pass = 0; pass < 2; pass++) begin
         for (int i = 0; i < 8; i++) chk_rd(idx_tab[i], rst_tab[i]);
         `CHK({cmp_mode_field, cmp_one_out_pin_oe, ref_tied_ground, cmp_enabled}, 6'h06)
         if (pass == 0) begin
            // every mode and invert pair, with writes aimed at the read-only levels
            set_raw(1'b1, 1'b0);
            for (int k = 0; k < 8; k++) begin
               wr(cmc_pkg::IDX_CFG, {2'b11, k[1:0], 1'b0, k[2:0]});
               chk_rd(cmc_pkg::IDX_CFG, {k[1], ~k[0], k[1:0], 1'b0, k[2:0]});
               `CHK({cmp_mode_field, cmp_enabled}, {k[2:0], (k[2:0] != 3'h0 && k[2:0] != 3'h7)})
               `CHK(cmp_outputs_routed, (k[2:0] == 3'h3 || k[2:0] == 3'h6))
            end
            // pin routing, with direction bits still gating the drivers, both cleared here
            wr(cmc_pkg::IDX_CFG, 8'h03);
            wr(cmc_pkg::IDX_TRA, 8'h3b);
            wr(cmc_pkg::IDX_TRC, 8'h2f);
            `CHK({cmp_one_out_pin_o, cmp_two_out_pin_o}, 2'b10)
            `CHK({cmp_one_out_pin_oe, cmp_two_out_pin_oe}, 2'b00)
            wr(cmc_pkg::IDX_CFG, 8'h33);
            set_raw(1'b0, 1'b1);
            `CHK({cmp_one_out_pin_o, cmp_two_out_pin_o}, 2'b10)
            wr(cmc_pkg::IDX_CFG, 8'h31);
            `CHK({cmp_one_out_pin_o, cmp_two_out_pin_o}, 2'b01)
            // timer gate source and comparator two synchronising latch
            wr(cmc_pkg::IDX_CFG, 8'h02);
            @(posedge sys_clk);
            external_gate_pin <= 1'b1;
            @(negedge sys_clk);
            `CHK(timer_gate, 1'b1)
            wr(cmc_pkg::IDX_AUX, 8'h00);
            gate_step(1'b0, 1'b0);
            wr(cmc_pkg::IDX_AUX, 8'h01);
            gate_step(1'b1, 1'b0);
            @(posedge sys_clk);
            timer_prescale_used <= 1'b1;
            gate_step(1'b1, 1'b1);
            // all 32 reference settings, then the unimplemented bits and power-down
            for (int k = 0; k < 32; k++) begin
               wr(cmc_pkg::IDX_VRC, {2'b11, k[4], 1'b1, k[3:0]});
               `CHK({ref_range_select, ref_level_value, ref_power_enable, ref_tied_ground}, {k[4:0], 2'b10})
            end
            chk_rd(cmc_pkg::IDX_VRC, 8'haf);
            wr(cmc_pkg::IDX_VRC, 8'h25);
            `CHK({ref_power_enable, ref_tied_ground}, 2'b01)
            // change flags, mismatch reference and interrupt gating
            set_raw(1'b0, 1'b0);
            axi_rd(ba(cmc_pkg::IDX_CFG), rd, rsp);
            wr(cmc_pkg::IDX_PIR, 8'h00);
            chk_rd(cmc_pkg::IDX_PIR, 8'h00);
            set_raw(1'b1, 1'b0);
            chk_rd(cmc_pkg::IDX_PIR, 8'h08);
            wr(cmc_pkg::IDX_PIR, 8'h00);
            chk_rd(cmc_pkg::IDX_PIR, 8'h08);
            axi_rd(ba(cmc_pkg::IDX_CFG), rd, rsp);
            wr(cmc_pkg::IDX_PIR, 8'h00);
            chk_rd(cmc_pkg::IDX_PIR, 8'h00);
            wr(cmc_pkg::IDX_PIR, 8'h10);
            chk_rd(cmc_pkg::IDX_PIR, 8'h10);
            wr(cmc_pkg::IDX_PIE, 8'h10);
            wr(cmc_pkg::IDX_GIC, 8'h40);
            `CHK(irq_request, 1'b0)
            wr(cmc_pkg::IDX_GIC, 8'hc0);
            `CHK(irq_request, 1'b1)
            @(posedge sys_clk);
            sleep_active <= 1'b1;
            @(negedge sys_clk);
            `CHK({wake_request, wake_to_vector, cmp_enabled}, 3'b111)
            wr(cmc_pkg::IDX_GIC, 8'h40);
            `CHK({irq_request, wake_request, wake_to_vector}, 3'b010)
            chk_rd(cmc_pkg::IDX_CFG, 8'h42);
            chk_rd(cmc_pkg::IDX_AUX, 8'h01);
            chk_rd(cmc_pkg::IDX_VRC, 8'h25);
            // unmapped and misaligned places
            axi_rd(12'h004, rd, rsp);
            `CHK({rsp, rd}, {cmc_pkg::RESP_SLVERR, 32'h0})
            axi_wr(12'h065, 8'h3f, rsp);
            `CHK(rsp, cmc_pkg::RESP_SLVERR)
            // quiet inputs, then a reset in mid-run
            set_raw(1'b0, 1'b0);
            @(posedge sys_clk);
            sleep_active <= 1'b0;
            reset <= 1'b1;
            repeat (3) @(posedge sys_clk);
            reset <= 1'b0;
         end
      end
      end_of_test;
   end
endmodule : cmc_ctrl_bench

// ===== verification/cmc_far_side.sv
// far side model: the two analog comparators and the timer clock with its prescaler
`timescale 1ns/1ns
module cmc_far_side #(
   parameter int HALF_PERIOD = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // analog input levels, arbitrary units
   input wire logic [7:0] vin_one_plus,
   input wire logic [7:0] vin_one_minus,
   input wire logic [7:0] vin_two_plus,
   input wire logic [7:0] vin_two_minus,
   // comparator results
   output logic cmp_one_raw,
   output logic cmp_two_raw,
   // timer clocks
   output logic timer_clk_src,
   output logic timer_prescaled_clk
);
   int tick;
   // a result is 1 only while the plus input is strictly above the minus input
   assign cmp_one_raw = (vin_one_plus > vin_one_minus);
   assign cmp_two_raw = (vin_two_plus > vin_two_minus);
   // divide by two on the rising edge, so the divided falling edge never meets the undivided one
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tick <= 0;
         timer_clk_src <= 1'b0;
         timer_prescaled_clk <= 1'b0;
      end else if (tick == HALF_PERIOD - 1) begin
         tick <= 0;
         timer_clk_src <= ~timer_clk_src;
         if (!timer_clk_src) timer_prescaled_clk <= ~timer_prescaled_clk;
      end else begin
         tick <= tick + 1;
      end
   end
endmodule : cmc_far_side
